// [hdl/pfs_pkg.sv]
`default_nettype none

package pfs_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_P6_DIR    = 8'h00;
  localparam logic [7:0] OFS_P8_DIR    = 8'h04;
  localparam logic [7:0] OFS_P9_DIR    = 8'h08;
  localparam logic [7:0] OFS_P6_DATA   = 8'h0c;
  localparam logic [7:0] OFS_P8_DATA   = 8'h10;
  localparam logic [7:0] OFS_P9_DATA   = 8'h14;
  localparam logic [7:0] OFS_P6_PIN    = 8'h18;
  localparam logic [7:0] OFS_P8_PIN    = 8'h1c;
  localparam logic [7:0] OFS_P9_PIN    = 8'h20;
  localparam logic [7:0] OFS_KEY_MASK  = 8'h24;
  localparam logic [7:0] OFS_INT_EN    = 8'h28;
  localparam logic [7:0] OFS_INT_SEL   = 8'h2c;
  localparam logic [7:0] OFS_SER_CTRL  = 8'h30;
  localparam logic [7:0] OFS_HOST_CTRL = 8'h34;
  localparam logic [7:0] OFS_STATUS    = 8'h38;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  RST_KEY_MASK = 8'hff;
  localparam logic [7:0]  RST_ZERO8    = 8'h00;
  localparam logic [15:0] RST_ZERO16   = 16'h0000;

  // ----------------------------------------
  // Serial control field positions
  // ----------------------------------------
  localparam int SER_CLK_EN0 = 0;
  localparam int SER_CLK_EN1 = 1;
  localparam int SER_SYNC    = 2;
  localparam int SER_RX_EN   = 3;
  localparam int SER_TX_EN   = 4;
  localparam int SER_W       = 5;

  // ----------------------------------------
  // Host control field positions
  // ----------------------------------------
  localparam int HC_SIDEBAND = 0;
  localparam int HC_FIFO     = 1;
  localparam int HC_CH1      = 2;
  localparam int HC_CH4      = 5;
  localparam int HC_ADDR_DEC = 6;
  localparam int HC_FAST_GA  = 7;
  localparam int HC_PWR_EV   = 8;
  localparam int HC_TWO_WIRE = 9;
  localparam int HC_EXCLK_S  = 10;
  localparam int HC_EXCLK_E  = 11;
  localparam int HC_W        = 12;

  // ----------------------------------------
  // Pin vector layout and widths
  // ----------------------------------------
  localparam int P6_W   = 8;
  localparam int P8_W   = 7;
  localparam int P9_W   = 8;
  localparam int P6_LSB = 0;
  localparam int P8_LSB = 8;
  localparam int P9_LSB = 15;
  localparam int PIN_W  = 23;
  localparam int INT_W  = 16;

endpackage : pfs_pkg

`default_nettype wire

// [hdl/pfs_sync_if.sv]
`default_nettype none

// Raw pin levels in, filtered levels out
interface pfs_sync_if;
  logic [pfs_pkg::PIN_W-1:0] raw;
  logic [pfs_pkg::PIN_W-1:0] clean;

  modport user (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : pfs_sync_if

`default_nettype wire

// [hdl/pfs_pin_sync.sv]
`default_nettype none

module pfs_pin_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Pin levels
  pfs_sync_if.sync  sif
);

  logic [pfs_pkg::PIN_W-1:0] stage1;
  logic [pfs_pkg::PIN_W-1:0] stage2;
  logic [pfs_pkg::PIN_W-1:0] stage3;
  logic [pfs_pkg::PIN_W-1:0] held;

  // ----------------------------------------
  // Three-stage chain per pin
  // ----------------------------------------
  // Stage 1 is read only by stage 2
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
    end else begin
      stage1 <= sif.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per-bit agreement filter; a bit moves only when stages 2 and 3 agree
  for (genvar i = 0; i < pfs_pkg::PIN_W; i++) begin : g_filt
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        held[i] <= 1'b1;
      end else if (stage2[i] == stage3[i]) begin
        held[i] <= stage3[i];
      end
    end
  end

  assign sif.clean = held;

endmodule : pfs_pin_sync

`default_nettype wire

// [hdl/pfs_top.sv]
// The address-and-strobe port and the address map were decided locally.
`default_nettype none

module pfs_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Port 6 pins
  input  wire logic [7:0]  p6_in,
  output logic      [7:0]  p6_out,
  output logic      [7:0]  p6_oe,
  // Port 8 pins
  input  wire logic [6:0]  p8_in,
  output logic      [6:0]  p8_out,
  output logic      [6:0]  p8_oe,
  // Port 9 pins
  input  wire logic [7:0]  p9_in,
  output logic      [7:0]  p9_out,
  output logic      [7:0]  p9_oe,
  // Peripheral drive, same clock
  input  wire logic        serial_clk_out,
  input  wire logic        serial_tx_data,
  input  wire logic        clkrun_drive,
  input  wire logic        clkrun_drive_en,
  input  wire logic        gate_addr20_value,
  input  wire logic        power_event_value,
  input  wire logic        two_wire_pull_low,
  input  wire logic        sys_clk_phase,
  // Peripheral inputs from pins
  output logic      [7:0]  key_input_n,
  output logic      [15:0] ext_int_input_n,
  output logic             serial_clock_in,
  output logic             serial_rx_data,
  output logic             host_powerdown_in,
  output logic             clkrun_in,
  output logic             two_wire_data_in,
  output logic             ext_clock_input,
  output logic             host_bus_enable_term
);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0]  p6_dir;
  logic [6:0]  p8_dir;
  logic [7:0]  p9_dir;
  logic [7:0]  p6_data;
  logic [6:0]  p8_data;
  logic [7:0]  p9_data;
  logic [7:0]  key_mask;
  logic [15:0] int_en;
  logic [15:0] int_sel;
  logic [pfs_pkg::SER_W-1:0] ser_ctrl;
  logic [pfs_pkg::HC_W-1:0]  host_ctrl;

  // Filtered pin levels
  logic [7:0] p6_lvl;
  logic [6:0] p8_lvl;
  logic [7:0] p9_lvl;

  // Next values of pin drive and peripheral inputs
  logic [7:0]  next_p6_out;
  logic [7:0]  next_p6_oe;
  logic [6:0]  next_p8_out;
  logic [6:0]  next_p8_oe;
  logic [7:0]  next_p9_out;
  logic [7:0]  next_p9_oe;
  logic [7:0]  next_key;
  logic [15:0] next_int;
  logic        next_hbe;
  logic        sck_in_mode;
  logic        sck_out_mode;
  logic        exclk_mode;
  logic [31:0] next_rdata;

  pfs_sync_if sif ();

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  assign sif.raw = {p9_in, p8_in, p6_in};

  pfs_pin_sync u_sync (
    .mclk  (mclk),
    .reset (reset),
    .sif   (sif.sync)
  );

  assign p6_lvl = sif.clean[pfs_pkg::P6_LSB +: pfs_pkg::P6_W];
  assign p8_lvl = sif.clean[pfs_pkg::P8_LSB +: pfs_pkg::P8_W];
  assign p9_lvl = sif.clean[pfs_pkg::P9_LSB +: pfs_pkg::P9_W];

  // ----------------------------------------
  // Shared pin decode
  // ----------------------------------------
  // Peripheral owns the pin when sel, else direction bit rules
  // Result is {out, oe}
  function automatic logic [1:0] pin_drive(
    input logic sel,
    input logic per_out,
    input logic per_oe,
    input logic dir,
    input logic data
  );
    pin_drive = sel ? {per_out, per_oe} : {data, dir};
  endfunction : pin_drive

  // Active-low request passes only when routed, else idles high
  function automatic logic gate_in(input logic on, input logic lvl);
    gate_in = on ? lvl : 1'b1;
  endfunction : gate_in

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Direction and data registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      p6_dir  <= pfs_pkg::RST_ZERO8;
      p8_dir  <= pfs_pkg::RST_ZERO8[6:0];
      p9_dir  <= pfs_pkg::RST_ZERO8;
      p6_data <= pfs_pkg::RST_ZERO8;
      p8_data <= pfs_pkg::RST_ZERO8[6:0];
      p9_data <= pfs_pkg::RST_ZERO8;
    end else if (reg_wr) begin
      unique case (reg_addr)
        pfs_pkg::OFS_P6_DIR:  p6_dir  <= reg_wdata[7:0];
        pfs_pkg::OFS_P8_DIR:  p8_dir  <= reg_wdata[6:0];
        pfs_pkg::OFS_P9_DIR:  p9_dir  <= reg_wdata[7:0];
        pfs_pkg::OFS_P6_DATA: p6_data <= reg_wdata[7:0];
        pfs_pkg::OFS_P8_DATA: p8_data <= reg_wdata[6:0];
        pfs_pkg::OFS_P9_DATA: p9_data <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Function-select registers
  // Keys start masked so no pin wakes the scanner before setup
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      key_mask  <= pfs_pkg::RST_KEY_MASK;
      int_en    <= pfs_pkg::RST_ZERO16;
      int_sel   <= pfs_pkg::RST_ZERO16;
      ser_ctrl  <= pfs_pkg::RST_ZERO8[pfs_pkg::SER_W-1:0];
      host_ctrl <= pfs_pkg::RST_ZERO16[pfs_pkg::HC_W-1:0];
    end else if (reg_wr) begin
      unique case (reg_addr)
        pfs_pkg::OFS_KEY_MASK:  key_mask  <= reg_wdata[7:0];
        pfs_pkg::OFS_INT_EN:    int_en    <= reg_wdata[15:0];
        pfs_pkg::OFS_INT_SEL:   int_sel   <= reg_wdata[15:0];
        pfs_pkg::OFS_SER_CTRL:  ser_ctrl  <= reg_wdata[pfs_pkg::SER_W-1:0];
        pfs_pkg::OFS_HOST_CTRL: host_ctrl <= reg_wdata[pfs_pkg::HC_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (reg_addr)
      pfs_pkg::OFS_P6_DIR:    next_rdata[7:0]  = p6_dir;
      pfs_pkg::OFS_P8_DIR:    next_rdata[6:0]  = p8_dir;
      pfs_pkg::OFS_P9_DIR:    next_rdata[7:0]  = p9_dir;
      pfs_pkg::OFS_P6_DATA:   next_rdata[7:0]  = p6_data;
      pfs_pkg::OFS_P8_DATA:   next_rdata[6:0]  = p8_data;
      pfs_pkg::OFS_P9_DATA:   next_rdata[7:0]  = p9_data;
      pfs_pkg::OFS_P6_PIN:    next_rdata[7:0]  = p6_lvl;
      pfs_pkg::OFS_P8_PIN:    next_rdata[6:0]  = p8_lvl;
      pfs_pkg::OFS_P9_PIN:    next_rdata[7:0]  = p9_lvl;
      pfs_pkg::OFS_KEY_MASK:  next_rdata[7:0]  = key_mask;
      pfs_pkg::OFS_INT_EN:    next_rdata[15:0] = int_en;
      pfs_pkg::OFS_INT_SEL:   next_rdata[15:0] = int_sel;
      pfs_pkg::OFS_SER_CTRL:  next_rdata[pfs_pkg::SER_W-1:0] = ser_ctrl;
      pfs_pkg::OFS_HOST_CTRL: next_rdata[pfs_pkg::HC_W-1:0]  = host_ctrl;
      pfs_pkg::OFS_STATUS:    next_rdata[4:0] = {host_ctrl[pfs_pkg::HC_TWO_WIRE],
                                                  exclk_mode, sck_out_mode,
                                                  sck_in_mode, next_hbe};
      default: ;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Mode terms
  // ----------------------------------------
  // Sideband, FIFO, channel and address-decode users claim the sideband pins
  assign next_hbe = host_ctrl[pfs_pkg::HC_SIDEBAND]
                  | host_ctrl[pfs_pkg::HC_FIFO]
                  | (|host_ctrl[pfs_pkg::HC_CH4:pfs_pkg::HC_CH1])
                  | host_ctrl[pfs_pkg::HC_ADDR_DEC];

  // Clock enable 1 wins over the output conditions
  assign sck_in_mode  = ser_ctrl[pfs_pkg::SER_CLK_EN1];
  assign sck_out_mode = !ser_ctrl[pfs_pkg::SER_CLK_EN1]
                      & (ser_ctrl[pfs_pkg::SER_SYNC]
                      | ser_ctrl[pfs_pkg::SER_CLK_EN0]);

  // External clock only while the pin is an input
  assign exclk_mode = !p9_dir[6] & !host_ctrl[pfs_pkg::HC_EXCLK_S]
                    & host_ctrl[pfs_pkg::HC_EXCLK_E];

  // ----------------------------------------
  // Port 6 drive and key inputs
  // ----------------------------------------
  // No peripheral drives port 6; only direction and data bits matter
  for (genvar i = 0; i < pfs_pkg::P6_W; i++) begin : g_p6
    assign {next_p6_out[i], next_p6_oe[i]} =
      pin_drive(1'b0, 1'b0, 1'b0, p6_dir[i], p6_data[i]);
    // Key path is taken from the pin in either direction
    assign next_key[i] = gate_in(!key_mask[i], p6_lvl[i]);
  end

  // ----------------------------------------
  // Port 8 drive
  // ----------------------------------------
  always_comb begin
    // Serial clock: input, output or plain port
    if (sck_in_mode) begin
      {next_p8_out[6], next_p8_oe[6]} = 2'b00;
    end else begin
      {next_p8_out[6], next_p8_oe[6]} =
        pin_drive(sck_out_mode, serial_clk_out, 1'b1, p8_dir[6], p8_data[6]);
    end
    {next_p8_out[5], next_p8_oe[5]} =
      pin_drive(ser_ctrl[pfs_pkg::SER_RX_EN], 1'b0, 1'b0,
                p8_dir[5], p8_data[5]);
    {next_p8_out[4], next_p8_oe[4]} =
      pin_drive(ser_ctrl[pfs_pkg::SER_TX_EN], serial_tx_data, 1'b1,
                p8_dir[4], p8_data[4]);
    {next_p8_out[3], next_p8_oe[3]} =
      pin_drive(next_hbe, 1'b0, 1'b0, p8_dir[3], p8_data[3]);
    {next_p8_out[2], next_p8_oe[2]} =
      pin_drive(next_hbe, clkrun_drive, clkrun_drive_en,
                p8_dir[2], p8_data[2]);
    {next_p8_out[1], next_p8_oe[1]} =
      pin_drive(host_ctrl[pfs_pkg::HC_FAST_GA], gate_addr20_value, 1'b1,
                p8_dir[1], p8_data[1]);
    {next_p8_out[0], next_p8_oe[0]} =
      pin_drive(host_ctrl[pfs_pkg::HC_PWR_EV], power_event_value, 1'b1,
                p8_dir[0], p8_data[0]);
  end

  // ----------------------------------------
  // Port 9 drive
  // ----------------------------------------
  // Two-wire data is open drain: it only ever pulls low
  assign {next_p9_out[7], next_p9_oe[7]} =
    pin_drive(host_ctrl[pfs_pkg::HC_TWO_WIRE], 1'b0, two_wire_pull_low,
              p9_dir[7], p9_data[7]);

  // Clock output follows the direction bit alone
  assign next_p9_out[6] = p9_dir[6] ? sys_clk_phase : 1'b0;
  assign next_p9_oe[6]  = p9_dir[6];

  for (genvar i = 0; i < 6; i++) begin : g_p9
    assign {next_p9_out[i], next_p9_oe[i]} =
      pin_drive(1'b0, 1'b0, 1'b0, p9_dir[i], p9_data[i]);
  end

  // ----------------------------------------
  // External interrupt routing
  // ----------------------------------------
  // Unrouted lines idle high, since requests are active low
  always_comb begin
    next_int = 16'hffff;
    next_int[7]  = gate_in(!int_sel[7] & int_en[7], p6_lvl[7]);
    // The serial pins keep their interrupt path in any role
    next_int[5]  = gate_in(int_en[5], p8_lvl[6]);
    next_int[4]  = gate_in(int_en[4], p8_lvl[5]);
    next_int[3]  = gate_in(int_en[3], p8_lvl[4]);
    next_int[15] = gate_in(!int_sel[15] & int_en[15], p9_lvl[7]);
    next_int[14] = gate_in(!int_sel[14] & int_en[14], p9_lvl[5]);
    next_int[13] = gate_in(!int_sel[13] & int_en[13], p9_lvl[4]);
    next_int[12] = gate_in(!int_sel[12] & int_en[12], p9_lvl[3]);
    next_int[0]  = gate_in(int_en[0], p9_lvl[2]);
    next_int[1]  = gate_in(int_en[1], p9_lvl[1]);
    next_int[2]  = gate_in(int_en[2], p9_lvl[0]);
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Pin drive; one cycle of latency traded for clean outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      p6_out <= 8'h00;
      p6_oe  <= 8'h00;
      p8_out <= 7'h00;
      p8_oe  <= 7'h00;
      p9_out <= 8'h00;
      p9_oe  <= 8'h00;
    end else begin
      p6_out <= next_p6_out;
      p6_oe  <= next_p6_oe;
      p8_out <= next_p8_out;
      p8_oe  <= next_p8_oe;
      p9_out <= next_p9_out;
      p9_oe  <= next_p9_oe;
    end
  end

  // Interrupt and key request lines
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      key_input_n     <= 8'hff;
      ext_int_input_n <= 16'hffff;
    end else begin
      key_input_n     <= next_key;
      ext_int_input_n <= next_int;
    end
  end

  // Peripheral inputs; idle values when the pin is not theirs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      serial_clock_in      <= 1'b1;
      serial_rx_data       <= 1'b1;
      host_powerdown_in    <= 1'b1;
      clkrun_in            <= 1'b1;
      two_wire_data_in     <= 1'b1;
      ext_clock_input      <= 1'b0;
      host_bus_enable_term <= 1'b0;
    end else begin
      serial_clock_in      <= gate_in(sck_in_mode, p8_lvl[6]);
      serial_rx_data       <= gate_in(ser_ctrl[pfs_pkg::SER_RX_EN], p8_lvl[5]);
      host_powerdown_in    <= gate_in(next_hbe, p8_lvl[3]);
      clkrun_in            <= gate_in(next_hbe, p8_lvl[2]);
      two_wire_data_in     <= gate_in(host_ctrl[pfs_pkg::HC_TWO_WIRE], p9_lvl[7]);
      ext_clock_input      <= exclk_mode & p9_lvl[6];
      host_bus_enable_term <= next_hbe;
    end
  end

endmodule : pfs_top

`default_nettype wire

// [testbench/pfs_top_asserts.sv]
`default_nettype none

module pfs_top_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // Register port
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Pins
  input wire logic [6:0]  p8_in,
  input wire logic [6:0]  p8_out,
  input wire logic [6:0]  p8_oe,
  input wire logic [7:0]  p9_out,
  input wire logic [7:0]  p9_oe,
  // Peripheral side
  input wire logic        clkrun_drive,
  input wire logic        clkrun_drive_en,
  input wire logic        sys_clk_phase,
  input wire logic [15:0] ext_int_input_n,
  input wire logic        serial_clock_in,
  input wire logic        serial_rx_data,
  input wire logic        host_powerdown_in,
  input wire logic        clkrun_in,
  input wire logic        ext_clock_input,
  input wire logic        host_bus_enable_term
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Register read and pin role checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Read data may only appear in the slot after a read strobe
  read_slot_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside its slot");
  // Interrupt inputs with no pin stay idle high
  idle_irq_a: assert property (&{ext_int_input_n[11:8], ext_int_input_n[6]})
    else $error("unrouted interrupt input active");
  pd_role_a: assert property (host_bus_enable_term |-> !p8_oe[3])
    else $error("power-down pin driven in host mode");
  pd_gate_a: assert property (!host_powerdown_in |-> host_bus_enable_term)
    else $error("power-down input active outside host mode");
  // Stable pin must have crossed the synchroniser within seven edges
  pd_follow_a: assert property ((host_bus_enable_term && $stable(p8_in[3]))[*7]
    |-> host_powerdown_in == p8_in[3])
    else $error("power-down input does not follow pin");
  clkrun_drive_a: assert property (host_bus_enable_term && $past(host_bus_enable_term)
    |-> p8_oe[2] == $past(clkrun_drive_en) && (!p8_oe[2] || p8_out[2] == $past(clkrun_drive)))
    else $error("clock-run pin drive wrong");
  clkrun_gate_a: assert property (!clkrun_in |-> host_bus_enable_term)
    else $error("clock-run input active outside host mode");
  rx_role_a: assert property (!serial_rx_data |-> !p8_oe[5])
    else $error("receive pin driven while receiving");
  sck_role_a: assert property (!serial_clock_in |-> !p8_oe[6])
    else $error("serial clock pin driven in input mode");
  exclk_role_a: assert property (ext_clock_input |-> !p9_oe[6])
    else $error("external clock pin driven");
  sysclk_out_a: assert property (p9_oe[6] && $past(p9_oe[6]) |-> p9_out[6] == $past(sys_clk_phase))
    else $error("clock output does not follow phase");
endmodule : pfs_top_chk

bind pfs_top pfs_top_chk chk_u (.mclk(mclk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .p8_in(p8_in), .p8_out(p8_out), .p8_oe(p8_oe), .p9_out(p9_out), .p9_oe(p9_oe),
  .clkrun_drive(clkrun_drive), .clkrun_drive_en(clkrun_drive_en), .sys_clk_phase(sys_clk_phase),
  .ext_int_input_n(ext_int_input_n), .serial_clock_in(serial_clock_in), .serial_rx_data(serial_rx_data),
  .host_powerdown_in(host_powerdown_in), .clkrun_in(clkrun_in), .ext_clock_input(ext_clock_input),
  .host_bus_enable_term(host_bus_enable_term));

`default_nettype wire

// [testbench/pfs_far_model.sv]
`default_nettype none

module pfs_far_model (
  // Clock
  input  wire logic        mclk,
  // Pad drive from the block
  input  wire logic [22:0] pad_out,
  input  wire logic [22:0] pad_oe,
  // Outside world levels
  input  wire logic [22:0] pad_ext,
  // Resolved pad levels and clock image
  output logic      [22:0] pad_lvl,
  output logic             clk_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph = 1'b0;

  // Driven pads show the block's value, the rest the outside level
  assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & pad_ext);
  // Phase toggles every rising edge so a frozen clock output shows up
  always @(posedge mclk) ph <= ~ph;
  assign clk_phase = ph;
endmodule : pfs_far_model

`default_nettype wire

// [testbench/tb.sv]
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus, block and far side
  // ----------------------------------------
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [22:0] ext = 23'h0;
  logic [6:0]  pv = 7'h00;
  wire  [22:0] lvl;
  wire  [22:0] pout;
  wire  [22:0] poe;
  logic [7:0]  key;
  logic [15:0] irq;
  logic        sck, rxd, pdn, ckr, twd, exc, hbe, phase;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  pfs_top dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .p6_in(lvl[7:0]), .p6_out(pout[7:0]), .p6_oe(poe[7:0]),
    .p8_in(lvl[14:8]), .p8_out(pout[14:8]), .p8_oe(poe[14:8]), .p9_in(lvl[22:15]), .p9_out(pout[22:15]),
    .p9_oe(poe[22:15]), .serial_clk_out(pv[0]), .serial_tx_data(pv[1]), .clkrun_drive(pv[2]),
    .clkrun_drive_en(pv[3]), .gate_addr20_value(pv[4]), .power_event_value(pv[5]), .two_wire_pull_low(pv[6]),
    .sys_clk_phase(phase), .key_input_n(key), .ext_int_input_n(irq), .serial_clock_in(sck),
    .serial_rx_data(rxd), .host_powerdown_in(pdn), .clkrun_in(ckr), .two_wire_data_in(twd),
    .ext_clock_input(exc), .host_bus_enable_term(hbe));
  pfs_far_model far_u (.mclk(mclk), .pad_out(pout), .pad_oe(poe), .pad_ext(ext), .pad_lvl(lvl),
    .clk_phase(phase));

  // 125 MHz clock
  always #4 mclk = ~mclk;
  // Hang guard; the run needs under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end

  // Bus cycles, waits and comparison
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, e);
  endtask : rd
  // Wait out synchroniser, filter and output flops
  task automatic st;
    repeat (8) @(posedge mclk);
    #1;
  endtask : st
  task automatic pins(input logic [22:0] e, input logic [6:0] p);
    @(posedge mclk);
    ext <= e;
    pv <= p;
  endtask : pins

  task automatic t_regs;
    rd(pfs_pkg::OFS_KEY_MASK, 32'hff, "mask reset");
    wr(8'h3c, 32'hffff);
    wr(pfs_pkg::OFS_STATUS, 32'hffff);
    rd(8'h3c, 32'h0, "unmapped");
    rd(pfs_pkg::OFS_STATUS, 32'h0, "status");
  endtask : t_regs

  task automatic t_port6;
    pins(23'h00005a, 7'h00);
    wr(pfs_pkg::OFS_KEY_MASK, 32'h0);
    st();
    chk("key open", key, 8'h5a);
    wr(pfs_pkg::OFS_KEY_MASK, 32'h81);
    st();
    chk("key mask", key, 8'hdb);
    wr(pfs_pkg::OFS_P6_DATA, 32'h3c);
    wr(pfs_pkg::OFS_P6_DIR, 32'hf0);
    st();
    chk("p6 out", {poe[7:0], pout[7:4], key}, 20'hf03bb);
    wr(pfs_pkg::OFS_INT_EN, 32'h80);
    st();
    chk("ext_int_input_7", irq[7], 1'b0);
    wr(pfs_pkg::OFS_INT_SEL, 32'h80);
    st();
    chk("ext_int_input_7 sel", irq[7], 1'b1);
    wr(pfs_pkg::OFS_INT_SEL, 32'h0);
  endtask : t_port6

  task automatic t_serial;
    logic [7:0] ctl [5] = '{8'h02, 8'h01, 8'h04, 8'h06, 8'h00};
    logic [3:0] exp [5] = '{4'h0, 4'hf, 4'hf, 4'h0, 4'h6};
    pins(23'h001100, 7'h01);
    wr(pfs_pkg::OFS_P8_DIR, 32'h40);
    wr(pfs_pkg::OFS_INT_EN, 32'h38);
    foreach (ctl[i]) begin
      wr(pfs_pkg::OFS_SER_CTRL, {24'h0, ctl[i]});
      st();
      chk("sck pin", {irq[5], sck, poe[14], pout[14] & poe[14]}, exp[i]);
    end
    wr(pfs_pkg::OFS_P8_DIR, 32'h70);
    wr(pfs_pkg::OFS_P8_DATA, 32'h30);
    wr(pfs_pkg::OFS_SER_CTRL, 32'h18);
    st();
    chk("rx tx", {poe[13:12], pout[12], rxd, irq[5:3]}, 7'h20);
    wr(pfs_pkg::OFS_SER_CTRL, 32'h0);
    st();
    chk("rx tx off", {poe[13:12], pout[12], rxd, irq[5:3]}, 7'h7b);
  endtask : t_serial

  task automatic t_host;
    wr(pfs_pkg::OFS_P8_DIR, 32'h0f);
    wr(pfs_pkg::OFS_P8_DATA, 32'h0);
    for (int b = 0; b < 7; b++) begin
      wr(pfs_pkg::OFS_HOST_CTRL, 32'h1 << b);
      st();
      chk("host en", {hbe, poe[11], pdn}, 3'b100);
    end
    pins(23'h001100, 7'h3b);
    wr(pfs_pkg::OFS_HOST_CTRL, 32'h1c0);
    st();
    chk("host out", {poe[10:8], pout[10:8]}, 6'h3b);
    pins(23'h001100, 7'h33);
    st();
    chk("clkrun in", {poe[10], ckr}, 2'b00);
    wr(pfs_pkg::OFS_HOST_CTRL, 32'h0);
    st();
    chk("host off", {hbe, poe[11:8], pout[10:8], ckr, pdn}, 10'h1e3);
  endtask : t_host

  task automatic t_port9;
    pins(23'h2d1100, 7'h40);
    wr(pfs_pkg::OFS_INT_EN, 32'h8000);
    wr(pfs_pkg::OFS_HOST_CTRL, 32'h200);
    st();
    chk("two wire", {poe[22], pout[22], twd, irq[15]}, 4'h8);
    pins(23'h2d1100, 7'h00);
    wr(pfs_pkg::OFS_INT_SEL, 32'h8000);
    st();
    chk("two wire free", {poe[22], twd, irq[15]}, 3'b001);
    wr(pfs_pkg::OFS_HOST_CTRL, 32'h800);
    st();
    chk("ext clk", {poe[21], exc}, 2'b01);
    wr(pfs_pkg::OFS_HOST_CTRL, 32'hc00);
    st();
    chk("ext clk sel", {poe[21], exc}, 2'b00);
    wr(pfs_pkg::OFS_P9_DIR, 32'h40);
    st();
    chk("clk out", {poe[21], exc}, 2'b10);
    wr(pfs_pkg::OFS_INT_SEL, 32'h0);
    wr(pfs_pkg::OFS_INT_EN, 32'h7007);
    st();
    chk("irq9 in", {irq[14:12], irq[2:0]}, 6'h1a);
    wr(pfs_pkg::OFS_P9_DATA, 32'h25);
    wr(pfs_pkg::OFS_P9_DIR, 32'h3f);
    st();
    chk("irq9 out", {poe[20:15], irq[14:12], irq[2:0]}, 12'hfe5);
    wr(pfs_pkg::OFS_INT_SEL, 32'h7000);
    st();
    chk("irq9 sel", irq, 16'hfffd);
  endtask : t_port9

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_port6();
    t_serial();
    t_host();
    t_port9();
    end_sim();
  end
endmodule : tb

`default_nettype wire
